// >>> rtl/ssc_pkg.sv
// What this block does
// - After power is good, the system reset stays asserted for at least the hold time of 1 ms.
// - A brown-out indication forces system reset in every power mode.
// - Active and standby use the precision brown-out comparator, all other modes the low-power one.
// - The precision path trips at its threshold and releases only when supply-good shows the higher level.
// - The low-power comparator forces system reset only in modes other than active and standby.
// - The power-fail warning never causes a system reset.
// - The power-fail comparator is powered only when enabled and in active or standby mode.
// - The warning flag reads one while the comparator is powered and reports the supply low.
// - The warning raises the power-fail interrupt request.
// - Program-memory writes are suppressed while the warning flag is one.
// - A two-bit field selects one of four falling-supply trip levels, with no comparator hysteresis.
// - The control register resets to zero, bit 7 is enable, bits 6:5 threshold, bits 3:0 unused.
// - Bit 4 of the control register is the read-only warning flag.
// Purpose: Constants for the supply supervisor control block.
// Assumes: A 25 MHz always-on clock.
// Notes: Register offsets are byte addresses on AXI4-Lite.
package ssc_pkg;
  localparam logic [11:0] PFCTL_OFF = 12'h0DC;
  localparam logic [11:0] STAT_OFF = 12'h0E0;
  localparam int EN_BIT = 7;
  localparam int THR_LSB = 5;
  localparam int WARN_BIT = 4;
  localparam logic [7:0] PFCTL_RST = 8'h00;
  localparam int CLK_HZ = 25000000;
  localparam int HOLD_US = 1000;
  localparam int HOLD_CYC = (CLK_HZ / 1000 * HOLD_US + 999) / 1000;
  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssc_pkg

// >>> rtl/ssc_top.sv
// Purpose: Supply supervisor digital control with an AXI4-Lite register port.
// Assumes: Comparator outputs are asynchronous; power mode comes from the same clock domain.
// Notes: Reset output is asserted combinationally and released through a synchronous hold.
`timescale 1ns/1ps
module ssc_top #(
  parameter int HOLD_CYCLES = ssc_pkg::HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic por_ok,
  input wire logic bor_hp_low,
  input wire logic supply_good_hp,
  input wire logic bor_lp_low,
  input wire logic pf_low,
  input wire logic [2:0] power_mode,
  output logic pf_comp_power,
  output logic [1:0] pf_trip_sel,
  output logic sys_reset_n,
  output logic powerfail_irq,
  input wire logic pm_write_req,
  output logic pm_write_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // The hold counter cannot serve a zero length, so refuse it at elaboration.
  if (HOLD_CYCLES < 1) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one.");
  end

  localparam int NS = 5;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q, s2_q, s3_q, filt_q;
  assign raw = {pf_low, bor_lp_low, supply_good_hp, bor_hp_low, por_ok};

  // Three stages, and a change counts only once the last two agree.
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          filt_q[g] <= 1'b0;
        end else if (aclken) begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            filt_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic por_ok_s, hp_low_s, good_s, lp_low_s, pf_low_s;
  assign {pf_low_s, lp_low_s, good_s, hp_low_s, por_ok_s} = filt_q;

  function automatic logic is_run_mode(input logic [2:0] m);
    is_run_mode = (m == ssc_pkg::MODE_ACTIVE) || (m == ssc_pkg::MODE_STANDBY);
  endfunction : is_run_mode

  logic run_mode;
  assign run_mode = is_run_mode(power_mode);

  // Latched brown-out from the precision path; cleared only at the release level.
  logic hp_trip_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hp_trip_q <= 1'b0;
    end else if (aclken) begin
      if (run_mode && hp_low_s) begin
        hp_trip_q <= 1'b1;
      end else if (good_s) begin
        hp_trip_q <= 1'b0;
      end
    end
  end

  // The comparator selection follows the mode so exactly one detector is in charge.
  logic bor_req;
  assign bor_req = run_mode ? (hp_low_s || hp_trip_q) : lp_low_s;

  logic rst_req;
  assign rst_req = !por_ok_s || bor_req; // Power-fail warning is not a term here.

  // Hold counter restarts on every request so release waits the full hold time.
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_q;
  logic released_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
      released_q <= 1'b0;
    end else if (aclken) begin
      if (rst_req) begin
        hold_q <= '0;
        released_q <= 1'b0;
      end else if (!released_q) begin
        if (hold_q == ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES - 1)) begin
          released_q <= 1'b1;
        end else begin
          hold_q <= hold_q + 1'b1;
        end
      end
    end
  end

  // Asserted at once on a request, released only by the clocked hold.
  assign sys_reset_n = aresetn && released_q && !rst_req;

  logic pf_en_q;
  logic [1:0] pf_thr_q;
  logic warn;
  assign pf_comp_power = pf_en_q && run_mode;
  assign pf_trip_sel = pf_thr_q;
  assign warn = pf_comp_power && pf_low_s;
  assign powerfail_irq = warn;
  assign pm_write_en = pm_write_req && !warn;

  // AXI4-Lite write side: address and data latched independently.
  logic aw_q, w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssc_pkg::RESP_OKAY;
    end else if (aclken) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q[11:2] == ssc_pkg::PFCTL_OFF[11:2] ||
            awaddr_q[11:2] == ssc_pkg::STAT_OFF[11:2]) begin
          s_axi_bresp <= ssc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= ssc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_en_q <= ssc_pkg::PFCTL_RST[ssc_pkg::EN_BIT];
      pf_thr_q <= ssc_pkg::PFCTL_RST[ssc_pkg::THR_LSB +: 2];
    end else if (aclken) begin
      if (aw_q && w_q && awaddr_q[11:2] == ssc_pkg::PFCTL_OFF[11:2] && wstrb_q[0]) begin
        pf_en_q <= wdata_q[ssc_pkg::EN_BIT];
        pf_thr_q <= wdata_q[ssc_pkg::THR_LSB +: 2];
      end
    end
  end

  // Read side; status word shows the block's own state for software.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ssc_pkg::RESP_OKAY;
    end else if (aclken) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ssc_pkg::RESP_OKAY;
        if (s_axi_araddr[11:2] == ssc_pkg::PFCTL_OFF[11:2]) begin
          s_axi_rdata <= {24'h000000, pf_en_q, pf_thr_q, warn, 4'h0};
        end else if (s_axi_araddr[11:2] == ssc_pkg::STAT_OFF[11:2]) begin
          s_axi_rdata <= {27'h0000000, pf_comp_power, run_mode, hp_trip_q, rst_req,
                          released_q};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= ssc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ssc_top

// >>> testbench/ssc_monitor.sv
// Purpose: Port checks for the supply supervisor.
// Assumes: Comparator inputs stay put for several cycles.
// Notes: Runs of six samples cover the input filter delay.
`timescale 1ns/1ps
module ssc_monitor #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_ok,
  input wire logic bor_hp_low,
  input wire logic supply_good_hp,
  input wire logic bor_lp_low,
  input wire logic pf_low,
  input wire logic [2:0] power_mode,
  input wire logic pf_comp_power,
  input wire logic sys_reset_n,
  input wire logic powerfail_irq,
  input wire logic pm_write_req,
  input wire logic pm_write_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int good_q = 0;
  logic run;
  assign run = power_mode == 3'h0 || power_mode == 3'h7;
  always_ff @(posedge aclk) good_q <= por_ok ? good_q + 1 : 0;
  property p_hold; $rose(sys_reset_n) |-> good_q >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_hp; (bor_hp_low && run)[*6] |-> !sys_reset_n; endproperty
  a_hp: assert property (p_hp) else $error("no reset");
  property p_lp; (bor_lp_low && !run)[*6] |-> !sys_reset_n; endproperty
  a_lp: assert property (p_lp) else $error("no reset");
  property p_hyst; (!supply_good_hp && !sys_reset_n)[*6] |=> !sys_reset_n; endproperty
  a_hyst: assert property (p_hyst) else $error("left reset");
  property p_quiet; (sys_reset_n && por_ok && !bor_hp_low && !bor_lp_low)[*6] |=> sys_reset_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray reset");
  property p_pwr; pf_comp_power |-> run; endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_warn; (!pf_low)[*6] |-> !powerfail_irq; endproperty
  a_warn: assert property (p_warn) else $error("warn");
  property p_wen; pm_write_en == (pm_write_req && !powerfail_irq); endproperty
  a_wen: assert property (p_wen) else $error("write gate");
  c_lp: cover property (!sys_reset_n && !run);
  c_irq: cover property (powerfail_irq && pm_write_req);
  c_pwr: cover property (pf_comp_power);
endmodule : ssc_monitor
bind ssc_top ssc_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) i_ssc_monitor (.*);

// >>> testbench/ssc_partner.sv
// Purpose: Supply comparators seen by the supervisor.
// Assumes: The bench sets the supply in millivolts.
// Notes: No hysteresis, so a warning clears right at the trip level.
`timescale 1ns/1ps
module ssc_partner (
  input wire logic [15:0] vdd,
  input wire logic [1:0] pf_trip_sel,
  input wire logic pf_comp_power,
  output logic por_ok,
  output logic bor_hp_low,
  output logic supply_good_hp,
  output logic bor_lp_low,
  output logic pf_low
);
  // Power-on detect only acts at power-up, so later dips test brown-out alone.
  initial por_ok = 1'b0;
  always @(vdd) if (vdd >= 16'h076C) por_ok = 1'b1;
  assign bor_hp_low = vdd < 16'h0708;
  assign supply_good_hp = vdd >= 16'h073A;
  assign bor_lp_low = vdd < 16'h05DC;
  assign pf_low = pf_comp_power && vdd < 16'h0834 + 16'h00C8 * pf_trip_sel;
endmodule : ssc_partner

// >>> testbench/supply_supervisor_ctrl_test.sv
// Purpose: Self-checking bench for the supply supervisor.
// Assumes: Short hold count of 8 cycles.
// Notes: Bus answers are taken at the rising edge at which they are handshaken.
`timescale 1ns/1ps
module supply_supervisor_ctrl_test;
  logic aclk = 1'b0, aresetn = 1'b0, aclken = 1'b1, pm_write_req = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ka, kw, kr, fin;
  logic [2:0] power_mode = 3'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q, v;
  logic [15:0] vdd = 16'h0000;
  logic [1:0] pf_trip_sel, s_axi_bresp, s_axi_rresp, resp;
  logic pf_comp_power, sys_reset_n, powerfail_irq, pm_write_en, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, por_ok, bor_hp_low, supply_good_hp;
  logic bor_lp_low, pf_low;
  int bad_count = 0, checks_done = 0, seed = 32'h33BC, lvl, n;
  int bo_q[$] = '{32'h6A4, 32'h71C, 32'h1010BB8, 32'h1020640, 32'h20578};
  initial forever #20 aclk = ~aclk;
  ssc_partner i_ssc_partner (.*);
  ssc_top #(.HOLD_CYCLES(8)) i_ssc_top (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge aclk);
      ka = s_axi_awvalid && s_axi_awready;
      kw = s_axi_wvalid && s_axi_wready;
      kr = s_axi_arvalid && s_axi_arready;
      fin = w ? s_axi_bvalid : s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp = w ? s_axi_bresp : s_axi_rresp;
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      if (kr) s_axi_arvalid <= 1'b0;
    end while (!fin);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : bus
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    vdd <= 16'h0BB8;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (sys_reset_n !== 1'b1);
    chk(n >= 8, 1);
    @(posedge aclk);
    bus(0, 12'h0DC, 32'h0);
    chk(rd_q, 32'h0);
    bus(0, 12'h0E0, 32'h0);
    chk(rd_q, 32'h9);
    bus(0, 12'h010, 32'h0);
    chk(resp, 2'h2);
    for (int t = 0; t < 4; t++) begin
      v = {24'h0, 1'b1, 2'(t), 5'($random(seed))};
      bus(1, 12'h0DC, v);
      chk(resp, 2'h0);
      chk(pf_trip_sel, t);
      lvl = 2100 + 200 * t;
      for (int k = -10; k <= 10; k += 20) begin
        vdd <= 16'(lvl + k);
        pm_write_req <= 1'($random(seed));
        repeat (8) @(posedge aclk);
        bus(0, 12'h0DC, 32'h0);
        chk(rd_q, (v & 32'hE0) | ((k < 0) << 4));
        chk(powerfail_irq, k < 0);
        chk(pm_write_en, pm_write_req && (k >= 0));
      end
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge aclk);
      power_mode <= 3'(m);
      @(negedge aclk);
      chk(pf_comp_power, m == 0 || m == 7);
    end
    foreach (bo_q[i]) begin
      power_mode <= 3'(bo_q[i] >> 16);
      vdd <= 16'(bo_q[i]);
      repeat (20) @(posedge aclk);
      chk(sys_reset_n, bo_q[i] >> 24);
    end
    // A reset in mid-run must bring the control register back to zero.
    vdd <= 16'h0BB8;
    power_mode <= 3'h0;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(sys_reset_n, 1);
    chk(pf_trip_sel, 0);
    bus(0, 12'h0DC, 32'h0);
    chk(rd_q, 32'h0);
    report_and_stop();
  end
endmodule : supply_supervisor_ctrl_test
